// ---- hw/tdf_formatter.sv ----
// telemetry downlist formatter: slot timing, list sequencing, mode flags, snapshots
// What this block does
// - sends a fixed 50-word block, repeated every second, twice per 2-s cycle
// - one word per 20-ms slot, only after a stop pulse is sensed
// - at each second's end the list position returns to the first word
// - at each block restart three cosines, ullage and self-test are snapshotted
// - each output word is 24 bits: 6-bit code then 18-bit data
// - the code is the word's list position, 01 to 62 octal
// - numeric data are two's complement, bit 17 is the sign
// - slots numbered 1 to 100; first list word in slots 1 and 51
// - time upper half increments once per 2 s during slot 2
// - unmarked words carry their value current at output time
// - readout flag set by readout key, cleared by clear or hold key
// - clear flag set by clear key, held until enter or readout key
// - readout while clear flag set sets readout flag as clear flag drops
// - enter keeps readout flag, puts entered word and address into words 2, 7
// - operator error on readout or enter zeros words 2 and 7
// - word 2 holds latest value; readout from clear mode delivers its data after half a second, otherwise at once
// - words 1, 2, 3 and 7 are sent live
// - cosine words use snapshot from slot 100 or slot 50
// - word 7 address sits in the low nine data bits
// - ullage/self-test word uses the snapshot from slot 100 or slot 50
`timescale 1ns/1ps
module tdf_formatter
  import tdf_pkg::*;
#(
  parameter int unsigned SLOT_CYCLES = SLOT_CYC,
  parameter int unsigned HALF_SLOTS  = HALF_READ_MS / SLOT_MS
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // telemetry equipment
  input  wire logic             stop_pulse,
  // display/keyboard unit
  input  wire tdf_keys_s        keys,
  input  wire tdf_word_t        readout_mem_data,
  // live and snapshot sources
  input  wire tdf_word_t        dir_cosine_row1_col1,
  input  wire tdf_word_t        dir_cosine_row1_col2,
  input  wire tdf_word_t        dir_cosine_row1_col3,
  input  wire tdf_word_t        ullage_self_test,
  input  wire tdf_word_t        time_lo,
  input  wire tdf_word_t        list_data,
  // status
  output tdf_word_t             time_hi,
  output logic [6:0]            slot_num,
  output logic                  readout_mode,
  output logic                  clear_mode,
  output logic [ADDR_W-1:0]     entry_address_word,
  output tdf_word_t             last_entered_value,
  // list data request
  output logic [5:0]            list_index,
  // telemetry stream
  output logic                  tlm_valid,
  input  wire logic             tlm_ready,
  output tdf_tlm_s              tlm_data,
  output logic                  word_dropped
);
  typedef struct packed {
    logic [$clog2(SLOT_CYCLES+1)-1:0] tick;
    logic [6:0]  slot;
    logic [5:0]  pos;
    logic        armed;
    logic        push;
    tdf_tlm_s    word;
    logic        drop;
    tdf_word_t   cos1, cos2, cos3, ull;
    tdf_word_t   thi;
    logic        rd_mode, clr_mode;
    logic [ADDR_W-1:0] addr;
    tdf_word_t   val;
    logic [6:0]  rd_wait;
  } tdf_state_s;

  tdf_state_s st_reg, st_next;
  logic       rst_s1_reg, rst_s2_reg;
  logic       f_ready;
  tdf_word_t  sel;

  function automatic logic [6:0] next_slot(input logic [6:0] s);
    next_slot = (s == SLOTS_PER_CYC) ? SLOT_FIRST : 7'(s + 7'h01);
  endfunction

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end

  assign list_index = st_reg.pos;

  // word selection: live words 1,2,3,7 and time; snapshots for cosines and ullage
  always_comb begin
    unique case (st_reg.pos)
      W_MODE_RD:  sel = st_reg.rd_mode ? SIGN_ONE : ZERO_W;
      W_LAST_VAL: sel = st_reg.val;
      W_MODE_CLR: sel = st_reg.clr_mode ? SIGN_ONE : ZERO_W;
      W_COS1:     sel = st_reg.cos1;
      W_COS2:     sel = st_reg.cos2;
      W_COS3:     sel = st_reg.cos3;
      W_ADDR:     sel = tdf_word_t'(st_reg.addr);
      W_ULLAGE:   sel = st_reg.ull;
      W_TIME_HI:  sel = st_reg.thi;
      default:    sel = list_data;
    endcase
  end

  always_comb begin
    st_next      = st_reg;
    st_next.push = 1'b0;
    st_next.drop = 1'b0;
    if (stop_pulse) begin
      st_next.armed = 1'b1;
    end
    if (st_reg.tick == ($bits(st_reg.tick))'(SLOT_CYCLES - 1)) begin
      st_next.tick = '0;
      st_next.slot = next_slot(st_reg.slot);
      if (st_reg.slot == SLOTS_PER_CYC || st_reg.slot == SLOT_HALF) begin
        st_next.pos  = FIRST_CODE;
        st_next.cos1 = dir_cosine_row1_col1;
        st_next.cos2 = dir_cosine_row1_col2;
        st_next.cos3 = dir_cosine_row1_col3;
        st_next.ull  = ullage_self_test;
      end
      if (next_slot(st_reg.slot) == SLOT_TIME_UPD) begin
        st_next.thi = st_reg.thi + 1'b1;
      end
      if (st_reg.rd_wait != '0) begin
        st_next.rd_wait = st_reg.rd_wait - 1'b1;
        if (st_reg.rd_wait == 7'h01) begin
          st_next.val = readout_mem_data;
        end
      end
    end else begin
      st_next.tick = st_reg.tick + 1'b1;
      if (st_reg.tick == '0 && st_reg.armed && st_reg.pos <= WORDS_PER_BLK) begin
        st_next.armed     = stop_pulse;
        st_next.word.code = st_reg.pos;
        st_next.word.data = sel;
        if (f_ready) begin
          st_next.push = 1'b1;
          st_next.pos  = st_reg.pos + 1'b1;
        end else begin
          st_next.drop = 1'b1;
        end
      end
    end
    // display/keyboard mode flags
    if (keys.clear_key) begin
      st_next.clr_mode = 1'b1;
      st_next.rd_mode  = 1'b0;
    end else if (keys.hold_key) begin
      st_next.rd_mode = 1'b0;
    end else if (keys.readout_key) begin
      st_next.clr_mode = 1'b0;
      // a newer readout or enter key press cancels a pending delayed readout load
      st_next.rd_wait  = '0;
      if (keys.op_error) begin
        st_next.val  = ZERO_W;
        st_next.addr = '0;
      end else begin
        st_next.rd_mode = 1'b1;
        st_next.addr    = keys.addr;
        if (st_reg.clr_mode) begin
          st_next.val     = ZERO_W;
          st_next.rd_wait = 7'(HALF_SLOTS);
        end else begin
          st_next.val = readout_mem_data;
        end
      end
    end else if (keys.enter_key) begin
      st_next.clr_mode = 1'b0;
      st_next.rd_wait  = '0;
      if (keys.op_error) begin
        st_next.val  = ZERO_W;
        st_next.addr = '0;
      end else begin
        st_next.val  = keys.entered;
        st_next.addr = keys.addr;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_s2_reg) begin
    if (!rst_s2_reg) begin
      st_reg      <= '0;
      st_reg.slot <= SLOT_FIRST;
      st_reg.pos  <= FIRST_CODE;
    end else begin
      st_reg <= st_next;
    end
  end

  tdf_fifo #(
    .WIDTH (TW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_s2_reg),
    .in_valid  (st_reg.push),
    .in_ready  (f_ready),
    .in_data   (st_reg.word),
    .out_valid (tlm_valid),
    .out_ready (tlm_ready),
    .out_data  (tlm_data)
  );

  assign time_hi            = st_reg.thi;
  assign slot_num           = st_reg.slot;
  assign readout_mode       = st_reg.rd_mode;
  assign clear_mode         = st_reg.clr_mode;
  assign entry_address_word = st_reg.addr;
  assign last_entered_value = st_reg.val;
  assign word_dropped       = st_reg.drop;
endmodule

// ---- include/tdf_pkg.sv ----
// package: constants and carrier types for the telemetry downlist formatter
package tdf_pkg;
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned SLOT_MS       = 20;
  localparam int unsigned SLOT_CYC      = CLK_HZ / 1000 * SLOT_MS;
  localparam int unsigned READOUT_MS    = 1000;
  localparam int unsigned HALF_READ_MS  = READOUT_MS / 2;
  localparam logic [5:0]  WORDS_PER_BLK = 6'h32;
  localparam logic [5:0]  FIRST_CODE    = 6'h01;
  localparam logic [6:0]  SLOTS_PER_CYC = 7'h64;
  localparam logic [6:0]  SLOT_FIRST    = 7'h01;
  localparam logic [6:0]  SLOT_HALF     = 7'h32;
  localparam logic [6:0]  SLOT_TIME_UPD = 7'h02;
  localparam logic [5:0]  W_MODE_RD     = 6'h01;
  localparam logic [5:0]  W_LAST_VAL    = 6'h02;
  localparam logic [5:0]  W_MODE_CLR    = 6'h03;
  localparam logic [5:0]  W_COS1        = 6'h04;
  localparam logic [5:0]  W_COS2        = 6'h05;
  localparam logic [5:0]  W_COS3        = 6'h06;
  localparam logic [5:0]  W_ADDR        = 6'h07;
  localparam logic [5:0]  W_ULLAGE      = 6'h1F;
  localparam logic [5:0]  W_TIME_HI     = 6'h2B;
  localparam int unsigned ADDR_W        = 9;
  localparam int unsigned DW            = 18;
  localparam int unsigned TW            = 24;
  localparam int unsigned FIFO_DEPTH    = 32;
  localparam logic [17:0] SIGN_ONE      = 18'h20000;
  localparam logic [17:0] ZERO_W        = 18'h00000;

  typedef logic [DW-1:0] tdf_word_t;

  typedef struct packed {
    logic clear_key;
    logic hold_key;
    logic enter_key;
    logic readout_key;
    logic op_error;
    logic [ADDR_W-1:0] addr;
    tdf_word_t         entered;
  } tdf_keys_s;

  typedef struct packed {
    logic [5:0] code;
    tdf_word_t  data;
  } tdf_tlm_s;
endpackage

// ---- hw/tdf_fifo.sv ----
// synchronous valid/ready fifo
`timescale 1ns/1ps
module tdf_fifo #(
  parameter int unsigned WIDTH = 24,
  parameter int unsigned DEPTH = 32
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // write side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // read side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } tdf_fifo_s;
  tdf_fifo_s        st_reg, st_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             full, empty, push, pop;

  assign full      = (st_reg.wp[AW] != st_reg.rp[AW]) && (st_reg.wp[AW-1:0] == st_reg.rp[AW-1:0]);
  assign empty     = st_reg.wp == st_reg.rp;
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign push      = in_valid && !full;
  assign pop       = out_ready && !empty;
  assign out_data  = mem[st_reg.rp[AW-1:0]];

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.wp = st_reg.wp + 1'b1;
    end
    if (pop) begin
      st_next.rp = st_reg.rp + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[st_reg.wp[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

// ---- bench/tdf_tlm_equip.sv ----
// telemetry equipment model: a stop pulse each slot and a stallable word drain
`timescale 1ns/1ps
module tdf_tlm_equip #(
  parameter int unsigned PERIOD = 20
) (
  // clock
  input  wire logic clk,
  // bench control
  input  wire logic stop_en,
  input  wire logic stall,
  // towards the formatter
  output logic      stop_pulse,
  output logic      tlm_ready
);
  int unsigned cnt = 0;
  initial begin
    stop_pulse = 1'b0;
    tlm_ready  = 1'b0;
  end
  always @(negedge clk) begin
    cnt        <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
    stop_pulse <= stop_en && (cnt == 7);
    tlm_ready  <= !stall && (cnt[1:0] != 2'h3);
  end
endmodule

// ---- bench/tdf_monitor.sv ----
// assertion checker bound to the downlist formatter
`timescale 1ns/1ps
module tdf_monitor
  import tdf_pkg::*;
(
  // clock and reset
  input wire logic              clk,
  input wire logic              resetn,
  // keys and status
  input wire tdf_keys_s         keys,
  input wire tdf_word_t         time_hi,
  input wire logic [6:0]        slot_num,
  input wire logic              readout_mode,
  input wire logic              clear_mode,
  input wire logic [ADDR_W-1:0] entry_address_word,
  input wire tdf_word_t         last_entered_value,
  input wire logic [5:0]        list_index,
  // stream
  input wire logic              tlm_valid,
  input wire logic              tlm_ready,
  input wire tdf_tlm_s          tlm_data,
  input wire logic              word_dropped
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire k_free = !keys.clear_key && !keys.hold_key;
  property p_clr; keys.clear_key |=> clear_mode && !readout_mode; endproperty
  a_clr: assert property (p_clr) else $error("clear key missed");
  property p_rd; k_free && keys.readout_key && !keys.op_error |=> readout_mode && !clear_mode;
  endproperty
  a_rd: assert property (p_rd) else $error("readout key missed");
  property p_ent; k_free && !keys.readout_key && keys.enter_key && !keys.op_error |=>
    $stable(readout_mode) && last_entered_value == $past(keys.entered)
    && entry_address_word == $past(keys.addr); endproperty
  a_ent: assert property (p_ent) else $error("enter key missed");
  property p_err; k_free && (keys.readout_key || keys.enter_key) && keys.op_error |=>
    $stable(readout_mode) && last_entered_value == ZERO_W && entry_address_word == '0;
  endproperty
  a_err: assert property (p_err) else $error("operator error not zeroed");
  property p_slot; $changed(slot_num) |-> slot_num == $past(slot_num) + 7'h01
    || ($past(slot_num) == SLOTS_PER_CYC && slot_num == SLOT_FIRST); endproperty
  a_slot: assert property (p_slot) else $error("slot step wrong");
  property p_time; $changed(time_hi) |->
    slot_num == SLOT_TIME_UPD && time_hi == $past(time_hi) + 18'h00001; endproperty
  a_time: assert property (p_time) else $error("time step wrong");
  property p_pos; $changed(list_index) |->
    list_index == $past(list_index) + 6'h01 || list_index == FIRST_CODE; endproperty
  a_pos: assert property (p_pos) else $error("position step wrong");
  property p_keep; tlm_valid && !tlm_ready |=> tlm_valid && $stable(tlm_data); endproperty
  a_keep: assert property (p_keep) else $error("word not held");
  property p_code; tlm_valid |-> tlm_data.code inside {[FIRST_CODE:WORDS_PER_BLK]};
  endproperty
  a_code: assert property (p_code) else $error("code out of range");
  c_drop: cover property (word_dropped);
  c_rd: cover property (clear_mode && keys.readout_key);
  c_last: cover property (tlm_valid && tlm_ready && tlm_data.code == WORDS_PER_BLK);
  c_time: cover property ($changed(time_hi));
endmodule
bind tdf_formatter tdf_monitor u_mon (.clk(clk), .resetn(resetn), .keys(keys),
  .time_hi(time_hi), .slot_num(slot_num), .readout_mode(readout_mode),
  .clear_mode(clear_mode), .entry_address_word(entry_address_word),
  .last_entered_value(last_entered_value), .list_index(list_index),
  .tlm_valid(tlm_valid), .tlm_ready(tlm_ready), .tlm_data(tlm_data),
  .word_dropped(word_dropped));

// ---- bench/test_tdf_formatter.sv ----
// self-checking bench for the telemetry downlist formatter
`timescale 1ns/1ps
module test_tdf_formatter;
  import tdf_pkg::*;
  localparam int unsigned SC = 20;
  logic       clk, resetn, stop_pulse, tlm_ready, tlm_valid, word_dropped;
  logic       readout_mode, clear_mode, stop_en, stall, v_ok;
  logic [5:0] list_index;
  logic [6:0] slot_num;
  logic [8:0] entry_address_word, m_addr;
  tdf_keys_s  keys;
  tdf_tlm_s   tlm_data;
  tdf_word_t  mem, c1, c2, c3, ull, tlo, time_hi, last_entered_value, m_val;
  int         n_mismatch, total_checks, n_rx, n_drop, n8, prev, cyc, m_rd, m_clr, t, r0;
  int         n_one;
  int         n_seen = -1;
  tdf_word_t  s1, s2, s3, s4;
  int         kinds[9] = '{0, 2, 1, 2, 3, 0, 3, 2, 3};
  bit         errs[9] = '{0, 0, 0, 0, 0, 0, 0, 1, 1};
  tdf_tlm_equip #(.PERIOD(SC)) u_equip (.clk(clk), .stop_en(stop_en), .stall(stall),
    .stop_pulse(stop_pulse), .tlm_ready(tlm_ready));
  tdf_formatter #(.SLOT_CYCLES(SC), .HALF_SLOTS(3)) DUT (.clk(clk), .resetn(resetn),
    .stop_pulse(stop_pulse), .keys(keys), .readout_mem_data(mem),
    .dir_cosine_row1_col1(c1), .dir_cosine_row1_col2(c2), .dir_cosine_row1_col3(c3),
    .ullage_self_test(ull), .time_lo(tlo), .list_data({12'hA5C, list_index}),
    .time_hi(time_hi), .slot_num(slot_num), .readout_mode(readout_mode),
    .clear_mode(clear_mode), .entry_address_word(entry_address_word),
    .last_entered_value(last_entered_value), .list_index(list_index),
    .tlm_valid(tlm_valid), .tlm_ready(tlm_ready), .tlm_data(tlm_data),
    .word_dropped(word_dropped));
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic slots(input int n);
    repeat (n * SC) @(negedge clk);
  endtask
  // one key press, applied just after word 8 so no live word is queued
  task automatic key(input int k, input bit e);
    int w, c0;
    w = n8;
    repeat (3000) if (n8 == w) @(negedge clk);
    @(negedge clk);
    keys = '0;
    keys.addr = ADDR_W'($urandom);
    keys.entered = DW'($urandom);
    keys.op_error = e;
    keys.clear_key = (k == 0);
    keys.hold_key = (k == 1);
    keys.readout_key = (k == 2);
    keys.enter_key = (k == 3);
    mem = DW'($urandom);
    c0 = m_clr;
    if (k == 0) m_clr = 1;
    if (k < 2) m_rd = 0;
    if (k == 2 && !e) m_rd = 1;
    if (k >= 2) begin
      m_clr = 0;
      m_addr = e ? '0 : keys.addr;
      m_val = e ? '0 : ((k == 2) ? mem : keys.entered);
      v_ok = 1'b1;
    end
    @(negedge clk);
    keys = '0;
    @(negedge clk);
    chk("readout_mode", readout_mode, m_rd[0]);
    chk("clear_mode", clear_mode, m_clr[0]);
    if (k == 3 || e) chk("value", {entry_address_word, last_entered_value}, {m_addr, m_val});
    // readout straight out of clear mode shows zero until the delayed load
    if (k == 2 && !e && c0 != 0) chk("value_wait", last_entered_value, 0);
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // snapshot sources change once after every first word, so live use would show
  always @(negedge clk) begin
    if (n_one != n_seen) begin
      n_seen = n_one;
      c1 = DW'($urandom);
      c2 = DW'($urandom);
      c3 = DW'($urandom);
      ull = DW'($urandom);
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      give_verdict();
    end
    if (word_dropped === 1'b1) n_drop++;
    if (resetn && tlm_valid === 1'b1 && tlm_ready === 1'b1) begin
      n_rx++;
      t = tlm_data.code;
      if (t == 1) begin
        n_one++;
        {s1, s2, s3, s4} = {c1, c2, c3, ull};
      end
      chk("code", (t == 1) || (t == prev + 1 && prev != 50), 1);
      case (tlm_data.code)
        W_MODE_RD: chk("word1", tlm_data.data[17], m_rd[0]);
        W_LAST_VAL: if (v_ok) chk("word2", tlm_data.data, m_val);
        W_MODE_CLR: chk("word3", tlm_data.data[17], m_clr[0]);
        W_ADDR: if (v_ok) chk("word7", tlm_data.data[8:0], m_addr);
        W_COS1: if (n_one > 1) chk("word4", tlm_data.data, s1);
        W_COS2: if (n_one > 1) chk("word5", tlm_data.data, s2);
        W_COS3: if (n_one > 1) chk("word6", tlm_data.data, s3);
        W_ULLAGE: if (n_one > 1) chk("word31", tlm_data.data, s4);
        W_TIME_HI: chk("word43", tlm_data.data, (n_one + 1) / 2);
        default: chk("word", tlm_data.data, {12'hA5C, tlm_data.code});
      endcase
      if (t == 8) n8++;
      prev = t;
    end
  end
  initial begin
    void'($urandom(91));
    resetn = 1'b0;
    stop_en = 1'b1;
    stall = 1'b0;
    v_ok = 1'b0;
    keys = '0;
    mem = DW'($urandom);
    tlo = DW'($urandom);
    {m_val, m_addr} = '0;
    repeat (20) @(negedge clk);
    resetn = 1'b1;
    slots(110);
    for (int i = 0; i < 9; i++) key(kinds[i], errs[i]);
    stop_en = 1'b0;
    slots(3);
    r0 = n_rx;
    slots(6);
    chk("no_stop_words", n_rx, r0);
    stop_en = 1'b1;
    stall = 1'b1;
    slots(45);
    chk("refused", n_drop > 0, 1);
    stall = 1'b0;
    repeat (500) if (tlm_valid !== 1'b0) @(negedge clk);
    chk("drained", tlm_valid, 0);
    slots(110);
    chk("blocks", n8 >= 10, 1);
    give_verdict();
  end
endmodule
